// ==== rtl/pin_direction_bank.sv ====
// one bank of data, direction and pullup-enable bits for a port
// assumes the owner decodes addresses and presents per-bank strobes
`timescale 1ns/1ps
module pin_direction_bank
    import port_pins_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_data_we,
    input wire logic i_dir_we,
    input wire logic i_pull_we,
    input wire logic [W-1:0] i_wdata,
    input wire logic [W-1:0] i_pin_in,
    output logic [W-1:0] o_data,
    output logic [W-1:0] o_dir,
    output logic [W-1:0] o_pull_en,
    output logic [W-1:0] o_pin_out,
    output logic [W-1:0] o_pin_oe,
    output logic [W-1:0] o_read_level
);
    logic [W-1:0] data_reg;
    logic [W-1:0] dir_reg;
    logic [W-1:0] pull_reg;

    // output latch clears on reset; its value only reaches the pin once dir is set
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            data_reg <= '0;
        end else if (i_data_we) begin
            data_reg <= i_wdata;
        end
    end

    // direction bits clear to input on reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dir_reg <= '0;
        end else if (i_dir_we) begin
            dir_reg <= i_wdata;
        end
    end

    // per-pin pullup enable
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pull_reg <= '0;
        end else if (i_pull_we) begin
            pull_reg <= i_wdata;
        end
    end

    assign o_data = data_reg;
    assign o_dir = dir_reg;
    assign o_pull_en = pull_reg;
    assign o_pin_out = data_reg;
    assign o_pin_oe = dir_reg;
    // outputs read back the latch, inputs the pin level
    assign o_read_level = (dir_reg & data_reg) | (~dir_reg & i_pin_in);
endmodule

// ==== rtl/port_pin_pullup_control.sv ====
// top of the port pin and pullup control block
// assumes synchronous pin inputs and a one-cycle-latency register port
// How it works
// - pullups enabled per pin by software, applied only when that pin is input
// - an output pin always has its pullup released
// - each keyboard port pin individually selectable for keypad interrupt duty
// - pullup forced on while a keyboard pin is on keypad interrupt duty
// - converter port has no pullups at all
// - each converter pin is either digital i/o or an analog channel
// - reset pin driven low while any internal reset source is active
// - external low on reset pin forces the startup state
// - two-bit port is plain i/o with input-only per-pin pullups
// - a set direction bit makes an output unless the pin is on keypad or analog duty; all clear to input on reset
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module port_pin_pullup_control
    import port_pins_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic [KEY_W-1:0] i_keyboard_capable_port,
    output logic [KEY_W-1:0] o_keyboard_capable_port,
    output logic [KEY_W-1:0] o_keyboard_capable_port_oe,
    output logic [KEY_W-1:0] o_keyboard_capable_pullup,
    output logic [KEY_W-1:0] o_keypad_interrupt_function,
    output logic [KEY_W-1:0] o_keypad_wake_input,
    input wire logic [CONV_W-1:0] i_converter_capable_port,
    output logic [CONV_W-1:0] o_converter_capable_port,
    output logic [CONV_W-1:0] o_converter_capable_port_oe,
    output logic [CONV_W-1:0] o_converter_analog_select,
    input wire logic [PLAIN_W-1:0] i_plain_two_bit_port,
    output logic [PLAIN_W-1:0] o_plain_two_bit_port,
    output logic [PLAIN_W-1:0] o_plain_two_bit_port_oe,
    output logic [PLAIN_W-1:0] o_plain_two_bit_pullup,
    input wire logic i_internal_reset_req,
    input wire logic i_reset_pin,
    output logic o_reset_pin,
    output logic o_reset_pin_oe,
    output logic o_system_reset_n
);
    // ********************************
    // effective pullup function
    // ********************************
    function automatic logic [KEY_W-1:0] pull_of(input logic [KEY_W-1:0] func,
                                                   input logic [KEY_W-1:0] en,
                                                   input logic [KEY_W-1:0] dir);
        pull_of = func | (en & ~dir);
    endfunction

    // ********************************
    // register decode
    // ********************************
    logic key_data_we, key_dir_we, key_pull_we;
    logic conv_data_we, conv_dir_we;
    logic plain_data_we, plain_dir_we, plain_pull_we;
    assign key_data_we = i_write && (i_addr == OFF_KEY_DATA);
    assign key_dir_we = i_write && (i_addr == OFF_KEY_DIR);
    assign key_pull_we = i_write && (i_addr == OFF_KEY_PULL);
    assign conv_data_we = i_write && (i_addr == OFF_CONV_DATA);
    assign conv_dir_we = i_write && (i_addr == OFF_CONV_DIR);
    assign plain_data_we = i_write && (i_addr == OFF_PLAIN_DATA);
    assign plain_dir_we = i_write && (i_addr == OFF_PLAIN_DIR);
    assign plain_pull_we = i_write && (i_addr == OFF_PLAIN_PULL);

    logic [KEY_W-1:0] key_data, key_dir, key_pull_en, key_rd;
    logic [CONV_W-1:0] conv_data, conv_dir, conv_rd;
    logic [PLAIN_W-1:0] plain_data, plain_dir, plain_pull_en, plain_rd;
    logic [KEY_W-1:0] key_func_reg;
    logic [CONV_W-1:0] conv_analog_reg;
    logic pin_reset_seen_reg;

    // ********************************
    // port banks
    // ********************************
    pin_direction_bank #(.W(KEY_W)) u_key (
        .i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_data_we(key_data_we), .i_dir_we(key_dir_we), .i_pull_we(key_pull_we),
        .i_wdata(i_wdata[KEY_W-1:0]), .i_pin_in(i_keyboard_capable_port),
        .o_data(key_data), .o_dir(key_dir), .o_pull_en(key_pull_en),
        .o_pin_out(o_keyboard_capable_port), .o_pin_oe(),
        .o_read_level(key_rd)
    );
    // the converter port never gets a pullup, so its enable strobe is tied off
    pin_direction_bank #(.W(CONV_W)) u_conv (
        .i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_data_we(conv_data_we), .i_dir_we(conv_dir_we), .i_pull_we(1'b0),
        .i_wdata(i_wdata[CONV_W-1:0]), .i_pin_in(i_converter_capable_port),
        .o_data(conv_data), .o_dir(conv_dir), .o_pull_en(),
        .o_pin_out(o_converter_capable_port), .o_pin_oe(),
        .o_read_level(conv_rd)
    );
    pin_direction_bank #(.W(PLAIN_W)) u_plain (
        .i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_data_we(plain_data_we), .i_dir_we(plain_dir_we), .i_pull_we(plain_pull_we),
        .i_wdata(i_wdata[PLAIN_W-1:0]), .i_pin_in(i_plain_two_bit_port),
        .o_data(plain_data), .o_dir(plain_dir), .o_pull_en(plain_pull_en),
        .o_pin_out(o_plain_two_bit_port), .o_pin_oe(o_plain_two_bit_port_oe),
        .o_read_level(plain_rd)
    );

    // ********************************
    // special function selects
    // ********************************
    // keypad duty per pin, any combination
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            key_func_reg <= '0;
        end else if (i_write && (i_addr == OFF_KEY_FUNC)) begin
            key_func_reg <= i_wdata[KEY_W-1:0];
        end
    end

    // analog channel select per converter pin
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            conv_analog_reg <= '0;
        end else if (i_write && (i_addr == OFF_CONV_ANALOG)) begin
            conv_analog_reg <= i_wdata[CONV_W-1:0];
        end
    end

    // ********************************
    // pin outputs
    // ********************************
    // keypad pins are inputs to the interrupt logic, so the driver stays off
    assign o_keyboard_capable_port_oe = key_dir & ~key_func_reg;
    assign o_keyboard_capable_pullup = pull_of(key_func_reg, key_pull_en, key_dir);
    assign o_keypad_interrupt_function = key_func_reg;
    assign o_keypad_wake_input = i_keyboard_capable_port & key_func_reg;
    // analog pins must not be driven, or the sample is corrupted
    assign o_converter_capable_port_oe = conv_dir & ~conv_analog_reg;
    assign o_converter_analog_select = conv_analog_reg;
    assign o_plain_two_bit_pullup = plain_pull_en & ~plain_dir;

    // ********************************
    // reset pin
    // ********************************
    // open drain: only ever drives low, the pin's own pullup gives the high
    assign o_reset_pin = 1'b0;
    assign o_reset_pin_oe = i_internal_reset_req | ~i_reset_n;
    // external low resets the system; the pin level is taken as synchronous
    assign o_system_reset_n = i_reset_pin & ~i_internal_reset_req;

    // sticky flag: pin seen low while not driven by us, cleared by reading
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_reset_seen_reg <= 1'b0;
        end else if (!i_reset_pin && !o_reset_pin_oe) begin
            pin_reset_seen_reg <= 1'b1; // set beats clear
        end else if (i_read && (i_addr == OFF_RESET_STAT)) begin
            pin_reset_seen_reg <= 1'b0;
        end
    end

    // ********************************
    // read port
    // ********************************
    logic [DATA_W-1:0] rdata_next;
    always_comb begin
        rdata_next = RST_ZERO;
        unique case (i_addr)
            OFF_KEY_DATA: rdata_next[KEY_W-1:0] = key_rd;
            OFF_CONV_DATA: rdata_next[CONV_W-1:0] = conv_rd;
            OFF_PLAIN_DATA: rdata_next[PLAIN_W-1:0] = plain_rd;
            OFF_KEY_DIR: rdata_next[KEY_W-1:0] = key_dir;
            OFF_CONV_DIR: rdata_next[CONV_W-1:0] = conv_dir;
            OFF_PLAIN_DIR: rdata_next[PLAIN_W-1:0] = plain_dir;
            OFF_KEY_PULL: rdata_next[KEY_W-1:0] = key_pull_en;
            OFF_PLAIN_PULL: rdata_next[PLAIN_W-1:0] = plain_pull_en;
            OFF_KEY_FUNC: rdata_next[KEY_W-1:0] = key_func_reg;
            OFF_CONV_ANALOG: rdata_next[CONV_W-1:0] = conv_analog_reg;
            OFF_RESET_STAT: rdata_next[POS_PIN_RESET] = pin_reset_seen_reg;
            default: rdata_next = RST_ZERO;
        endcase
    end

    // read data stands only in the cycle after the strobe
    logic [DATA_W-1:0] rdata_reg;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_reg <= RST_ZERO;
        end else if (i_read) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= RST_ZERO;
        end
    end
    assign o_rdata = rdata_reg;

    // ********************************
    // checks
    // ********************************
    chk_out_no_pull: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_keyboard_capable_port_oe != 0) |->
        ((o_keyboard_capable_port_oe & o_keyboard_capable_pullup) == 0))
        else $error("driven keyboard pin has pullup");
    chk_key_func_pull: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (key_func_reg & ~o_keyboard_capable_pullup) == 0)
        else $error("keypad pin lacks pullup");
    chk_pull_formula: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_keyboard_capable_pullup == (key_func_reg | (key_pull_en & ~key_dir)))
        else $error("keyboard pullup mismatch");
    chk_pull_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        key_pull_we && (key_dir == 0) && (key_func_reg == 0) && !key_dir_we |=>
        o_keyboard_capable_pullup == $past(i_wdata[KEY_W-1:0]))
        else $error("pullup write not applied");
    chk_plain_pull: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_plain_two_bit_pullup & o_plain_two_bit_port_oe) == 0)
        else $error("plain port pull while driving");
    chk_analog_float: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_converter_capable_port_oe & o_converter_analog_select) == 0)
        else $error("analog pin driven");
    chk_reset_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_internal_reset_req |-> o_reset_pin_oe && !o_reset_pin && !o_system_reset_n)
        else $error("reset pin not driven low");
    chk_dir_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        conv_dir_we && (conv_analog_reg == 0) && !(i_write && i_addr == OFF_CONV_ANALOG)
        |=> o_converter_capable_port_oe == $past(i_wdata[CONV_W-1:0]))
        else $error("direction write not applied");
    chk_ext_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !i_reset_pin |-> !o_system_reset_n)
        else $error("external reset ignored");
    chk_flag_set_wins: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!i_reset_pin && !o_reset_pin_oe) |=> pin_reset_seen_reg)
        else $error("pin reset flag not set");
endmodule

// ==== rtl/port_pins_pkg.sv ====
// package for the port pin and pullup control block
// assumes a single 40 MHz clock domain and an 8-bit register port
package port_pins_pkg;
    // ********************************
    // widths
    // ********************************
    localparam int KEY_W = 4;
    localparam int CONV_W = 6;
    localparam int PLAIN_W = 2;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // ********************************
    // register offsets
    // ********************************
    localparam logic [3:0] OFF_KEY_DATA = 4'h0;
    localparam logic [3:0] OFF_CONV_DATA = 4'h1;
    localparam logic [3:0] OFF_PLAIN_DATA = 4'h2;
    localparam logic [3:0] OFF_KEY_DIR = 4'h4;
    localparam logic [3:0] OFF_CONV_DIR = 4'h5;
    localparam logic [3:0] OFF_PLAIN_DIR = 4'h6;
    localparam logic [3:0] OFF_KEY_PULL = 4'h8;
    localparam logic [3:0] OFF_PLAIN_PULL = 4'h9;
    localparam logic [3:0] OFF_KEY_FUNC = 4'hA;
    localparam logic [3:0] OFF_CONV_ANALOG = 4'hB;
    localparam logic [3:0] OFF_RESET_STAT = 4'hC;
    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    // field position of the pin reset flag in the status register
    localparam int POS_PIN_RESET = 0;
endpackage

// ==== verification/board_pin_model.sv ====
// board-side model of the port pins and the shared reset line
// assumes the dut splits each pin into drive value and output enable
`timescale 1ns/1ps
module board_pin_model
    import port_pins_pkg::*;
(
    input wire logic [KEY_W-1:0] i_key_out,
    input wire logic [KEY_W-1:0] i_key_oe,
    input wire logic [KEY_W-1:0] i_key_board,
    input wire logic [CONV_W-1:0] i_conv_out,
    input wire logic [CONV_W-1:0] i_conv_oe,
    input wire logic [CONV_W-1:0] i_conv_board,
    input wire logic [PLAIN_W-1:0] i_plain_out,
    input wire logic [PLAIN_W-1:0] i_plain_oe,
    input wire logic [PLAIN_W-1:0] i_plain_board,
    input wire logic i_rst_out,
    input wire logic i_rst_oe,
    input wire logic i_rst_hold_low,
    output logic [KEY_W-1:0] o_key_pin,
    output logic [CONV_W-1:0] o_conv_pin,
    output logic [PLAIN_W-1:0] o_plain_pin,
    output logic o_rst_pin
);
    // ********************************
    // wire resolution
    // ********************************
    // released bits carry the board's own level, as set by the bench's kb, cb and pb
    assign o_key_pin = (i_key_oe & i_key_out) | (~i_key_oe & i_key_board);
    assign o_conv_pin = (i_conv_oe & i_conv_out) | (~i_conv_oe & i_conv_board);
    assign o_plain_pin = (i_plain_oe & i_plain_out) | (~i_plain_oe & i_plain_board);
    // pullup keeps the line high unless either party pulls it low
    assign o_rst_pin = ~((i_rst_oe & ~i_rst_out) | i_rst_hold_low);
endmodule

// ==== verification/port_pin_pullup_control_tb_top.sv ====
// self-checking bench for the port pin and pullup control block
// assumes the board model resolves every pin that the dut drives
`timescale 1ns/1ps
module port_pin_pullup_control_tb_top;
    import port_pins_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = 4'h0;
    logic [DATA_W-1:0] i_wdata = 8'h00, o_rdata;
    logic i_write = 1'b0, i_read = 1'b0, i_internal_reset_req = 1'b0, hold_low = 1'b0;
    logic [KEY_W-1:0] kb = 4'h0, kdir, kpull, kfunc, klat, kpin, kout, koe, kpu, kfn, kwake;
    logic [CONV_W-1:0] cb = 6'h00, cdir, cana, clat, cpin, cout, coe, csel;
    logic [PLAIN_W-1:0] pb = 2'h0, pdir, ppull, plat, ppin, pout, poe, ppu;
    logic rpin, rout, roe, sys_n, rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    int errors = 0, cmp_count = 0, cycles = 0, seed = 32'h04CEEA58;
    always #12.5 i_clk = ~i_clk;
    port_pin_pullup_control i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
        .i_keyboard_capable_port(kpin), .o_keyboard_capable_port(kout),
        .o_keyboard_capable_port_oe(koe), .o_keyboard_capable_pullup(kpu),
        .o_keypad_interrupt_function(kfn), .o_keypad_wake_input(kwake),
        .i_converter_capable_port(cpin), .o_converter_capable_port(cout),
        .o_converter_capable_port_oe(coe), .o_converter_analog_select(csel),
        .i_plain_two_bit_port(ppin), .o_plain_two_bit_port(pout), .o_plain_two_bit_port_oe(poe),
        .o_plain_two_bit_pullup(ppu), .i_internal_reset_req(i_internal_reset_req),
        .i_reset_pin(rpin), .o_reset_pin(rout), .o_reset_pin_oe(roe), .o_system_reset_n(sys_n));
    board_pin_model i_board (.i_key_out(kout), .i_key_oe(koe), .i_key_board(kb),
        .i_conv_out(cout), .i_conv_oe(coe), .i_conv_board(cb), .i_plain_out(pout),
        .i_plain_oe(poe), .i_plain_board(pb), .i_rst_out(rout), .i_rst_oe(roe),
        .i_rst_hold_low(hold_low), .o_key_pin(kpin), .o_conv_pin(cpin), .o_plain_pin(ppin),
        .o_rst_pin(rpin));
    // ********************************
    // shared tasks
    // ********************************
    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task finish_test;
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one-cycle strobes with a spare cycle so no signal is assigned twice in a step
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_write <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_read <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_clk);
        i_read <= 1'b0;
    endtask
    task chk_pins;
        @(negedge i_clk);
        check("key pullup", 8'(kfunc | (kpull & ~kdir)), 8'(kpu));
        check("key oe", 8'(kdir & ~kfunc), 8'(koe));
        check("key select", 8'(kfunc), 8'(kfn));
        check("key wake", 8'(kb & kfunc), 8'(kwake));
        check("plain pullup", 8'(ppull & ~pdir), 8'(ppu));
        check("plain oe", 8'(pdir), 8'(poe));
        check("conv oe", 8'(cdir & ~cana), 8'(coe));
        check("conv analog", 8'(cana), 8'(csel));
    endtask
    // ********************************
    // read-data watcher and timeout
    // ********************************
    // read data stand only in the cycle after the strobe, zero otherwise
    always @(posedge i_clk) rd_pend <= i_read;
    always @(negedge i_clk) begin
        if (rd_pend) begin
            if (exp_q.size() == 0) check("o_rdata unexpected", 8'h00, 8'hFF);
            else check("o_rdata", exp_q.pop_front(), o_rdata);
        end else if (i_reset_n) begin
            check("o_rdata idle", 8'h00, o_rdata);
        end
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    // ********************************
    // main sequence
    // ********************************
    initial begin
        {kdir, kpull, kfunc, pdir, ppull, cdir, cana} = '0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(OFF_KEY_DIR, 8'h00);
        rd(OFF_CONV_DIR, 8'h00);
        rd(OFF_PLAIN_DIR, 8'h00);
        chk_pins();
        // random configurations, upper data bits random too
        repeat (25) begin
            {kdir, kpull, kfunc, pdir, ppull, cdir, cana} = 28'($random(seed));
            kb <= 4'($random(seed));
            wr(OFF_KEY_DIR, {4'($random(seed)), kdir});
            wr(OFF_KEY_PULL, {4'($random(seed)), kpull});
            wr(OFF_KEY_FUNC, {4'($random(seed)), kfunc});
            wr(OFF_PLAIN_DIR, {6'($random(seed)), pdir});
            wr(OFF_PLAIN_PULL, {6'($random(seed)), ppull});
            wr(OFF_CONV_DIR, {2'($random(seed)), cdir});
            wr(OFF_CONV_ANALOG, {2'($random(seed)), cana});
            chk_pins();
            rd(OFF_KEY_PULL, 8'(kpull));
            rd(OFF_KEY_FUNC, 8'(kfunc));
            rd(OFF_CONV_ANALOG, 8'(cana));
        end
        // data path: output pins read the latch, input pins the board level
        kfunc = '0;
        cana = '0;
        wr(OFF_KEY_FUNC, 8'h00);
        wr(OFF_CONV_ANALOG, 8'h00);
        repeat (10) begin
            {klat, clat, plat} = 12'($random(seed));
            {kb, cb, pb} <= 12'($random(seed));
            wr(OFF_KEY_DATA, 8'(klat));
            wr(OFF_CONV_DATA, 8'(clat));
            wr(OFF_PLAIN_DATA, 8'(plat));
            // drive values follow the latches whatever the direction
            @(negedge i_clk);
            check("key drive", 8'(klat), 8'(kout));
            check("conv drive", 8'(clat), 8'(cout));
            check("plain drive", 8'(plat), 8'(pout));
            rd(OFF_KEY_DATA, 8'((kdir & klat) | (~kdir & kb)));
            rd(OFF_CONV_DATA, 8'((cdir & clat) | (~cdir & cb)));
            rd(OFF_PLAIN_DATA, 8'((pdir & plat) | (~pdir & pb)));
        end
        // unmapped place reads zero and ignores writes
        wr(4'h3, 8'hA5);
        rd(4'h3, 8'h00);
        // internal reset source pulls the line low
        @(posedge i_clk);
        i_internal_reset_req <= 1'b1;
        @(negedge i_clk);
        check("reset oe", 8'h01, 8'(roe));
        check("reset pin", 8'h00, 8'(rpin));
        check("system reset", 8'h00, 8'(sys_n));
        @(posedge i_clk);
        i_internal_reset_req <= 1'b0;
        rd(OFF_RESET_STAT, 8'h00);
        // board holds the line low from outside
        hold_low <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        check("system reset ext", 8'h00, 8'(sys_n));
        @(posedge i_clk);
        hold_low <= 1'b0;
        @(negedge i_clk);
        check("system reset free", 8'h01, 8'(sys_n));
        rd(OFF_RESET_STAT, 8'h01);
        rd(OFF_RESET_STAT, 8'h00);
        // mid-run reset clears every direction and select bit
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        {kdir, kpull, kfunc, pdir, ppull, cdir, cana} = '0;
        chk_pins();
        check("reset oe in reset", 8'h01, 8'(roe));
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(OFF_KEY_DIR, 8'h00);
        rd(OFF_PLAIN_PULL, 8'h00);
        repeat (3) @(posedge i_clk);
        finish_test();
    end
endmodule
